// ---- rtl/dtc_torque_cutoff.v ----
`timescale 1ns/100ps
`include "dtc_defs.vh"

// Functional notes
// - each of two channels trips independently
// - run only while both inputs closed
// - trip cuts gating, forces power switches off
// - trip lets motor coast, no ramp
// - latch trip, show error indication
// - clear needs both closed, then reset key
// - safe state within 10 ms of opening
// - normally closed completion relay on cutoff
// - power-on self-test, fault on relay outputs
module dtc_torque_cutoff #(
  parameter TEST_CYC = `DTC_TEST_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire safetyInputA,
  input wire safetyInputB,
  input wire resetKey,
  input wire runCmd,
  input wire selfTestOk,
  output reg gateEnable_q,
  output reg powerSwitchOff_q,
  output reg coast_q,
  output reg safetyErr_q,
  output reg completionRelayPos_q,
  output reg completionRelayNeg_q,
  output reg selfTestFail_q
);

  wire chanOneClosed;
  wire chanTwoClosed;
  wire chanOneRaw;
  wire chanTwoRaw;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] testCnt_q;
  reg keySync1_q;
  reg keySync2_q;
  reg keyPrev_q;
  reg okSync1_q;
  reg okSync2_q;
  wire bothClosed;
  wire keyPress;
  wire tripNow;

  // run state with both channels still closed; shared by the gating, power, coast and relay outputs
  function runGranted;
    input [1:0] st;
    input trip;
    begin
      runGranted = (st == `DTC_ST_RUN) & ~trip;
    end
  endfunction

  dtc_chan_filter #(
    .FILT_CYC(`DTC_FILT_CYC)
  ) uChanOne (
    .clock(clock),
    .rst_n(rst_n),
    .chanIn(safetyInputA),
    .chanClosed_q(chanOneClosed),
    .chanRaw_q(chanOneRaw)
  );

  dtc_chan_filter #(
    .FILT_CYC(`DTC_FILT_CYC)
  ) uChanTwo (
    .clock(clock),
    .rst_n(rst_n),
    .chanIn(safetyInputB),
    .chanClosed_q(chanTwoClosed),
    .chanRaw_q(chanTwoRaw)
  );

  // key comes from a panel switch outside the clock domain;
  // idle low after reset, so no false press follows reset
  always @(posedge clock) begin
    if (!rst_n) begin
      keySync1_q <= 1'h0;
      keySync2_q <= 1'h0;
      keyPrev_q <= 1'h0;
    end else begin
      keySync1_q <= resetKey;
      keySync2_q <= keySync1_q;
      keyPrev_q <= keySync2_q;
    end
  end

  // self-test status is async too; only its second stage is read
  always @(posedge clock) begin
    if (!rst_n) begin
      okSync1_q <= 1'h0;
      okSync2_q <= 1'h0;
    end else begin
      okSync1_q <= selfTestOk;
      okSync2_q <= okSync1_q;
    end
  end

  assign keyPress = keySync2_q & ~keyPrev_q;
  // trip on the raw synchronised level, not the filtered one,
  // so the reaction takes a few cycles, far inside the deadline
  assign tripNow = ~chanOneRaw | ~chanTwoRaw;
  assign bothClosed = chanOneClosed & chanTwoClosed;

  // self-test window length counter
  always @(posedge clock) begin
    if (!rst_n) begin
      testCnt_q <= 16'h0000;
    end else if (state_q == `DTC_ST_TEST && testCnt_q < TEST_CYC) begin
      testCnt_q <= testCnt_q + 16'h0001;
    end
  end

  // control sequence
  always @* begin
    state_d = state_q;
    case (state_q)
      `DTC_ST_TEST: begin
        if (testCnt_q >= TEST_CYC) begin
          if (!okSync2_q) begin
            state_d = `DTC_ST_FAIL;
          end else if (bothClosed && !tripNow) begin
            state_d = `DTC_ST_RUN;
          end else begin
            state_d = `DTC_ST_TRIP;
          end
        end
      end
      `DTC_ST_RUN: begin
        if (tripNow) begin
          state_d = `DTC_ST_TRIP;
        end
      end
      `DTC_ST_TRIP: begin
        // key only honoured once both channels are settled closed
        if (keyPress && bothClosed && !tripNow) begin
          state_d = `DTC_ST_RUN;
        end else begin
          state_d = `DTC_ST_TRIP;
        end
      end
      `DTC_ST_FAIL: begin
        state_d = `DTC_ST_FAIL;
      end
      default: begin
        state_d = `DTC_ST_FAIL;
      end
    endcase
  end

  // control state register
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= `DTC_ST_TEST;
    end else begin
      state_q <= state_d;
    end
  end

  // gating follows the trip in the same edge as the state change
  always @(posedge clock) begin
    if (!rst_n) begin
      gateEnable_q <= 1'h0;
    end else begin
      gateEnable_q <= runGranted(state_d, tripNow) & runCmd;
    end
  end

  // power modules forced off whenever run is not granted
  always @(posedge clock) begin
    if (!rst_n) begin
      powerSwitchOff_q <= 1'h1;
    end else begin
      powerSwitchOff_q <= ~runGranted(state_d, tripNow);
    end
  end

  // no ramp on a trip: drive just stops and the motor coasts
  always @(posedge clock) begin
    if (!rst_n) begin
      coast_q <= 1'h1;
    end else begin
      coast_q <= ~runGranted(state_d, tripNow);
    end
  end

  // error indication stands while the trip is latched
  always @(posedge clock) begin
    if (!rst_n) begin
      safetyErr_q <= 1'h0;
    end else begin
      safetyErr_q <= (state_d == `DTC_ST_TRIP);
    end
  end

  // b-contact: closed (1) in normal run, opens on cutoff or fault
  always @(posedge clock) begin
    if (!rst_n) begin
      completionRelayPos_q <= 1'h0;
    end else begin
      completionRelayPos_q <= runGranted(state_d, tripNow);
    end
  end

  // second relay side has its own flop, so one stuck driver
  // cannot hold both sides closed
  always @(posedge clock) begin
    if (!rst_n) begin
      completionRelayNeg_q <= 1'h0;
    end else begin
      completionRelayNeg_q <= runGranted(state_d, tripNow);
    end
  end

  // self-test fault stays latched until the next reset
  always @(posedge clock) begin
    if (!rst_n) begin
      selfTestFail_q <= 1'h0;
    end else begin
      selfTestFail_q <= (state_d == `DTC_ST_FAIL);
    end
  end

endmodule // dtc_torque_cutoff

// ---- rtl/dtc_defs.vh ----
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// reaction deadline in microseconds
`define DTC_DEADLINE_US 32'h00002710
// clock rate in MHz
`define DTC_CLK_MHZ 32'h00000032
// input filter length in cycles, well inside the deadline
`define DTC_FILT_CYC 16'h03E8
// self-test length in cycles after reset release
`define DTC_TEST_CYC 16'h0040
// controller states
`define DTC_ST_TEST 2'h0
`define DTC_ST_RUN 2'h1
`define DTC_ST_TRIP 2'h2
`define DTC_ST_FAIL 2'h3

`endif

// ---- rtl/dtc_chan_filter.v ----
`timescale 1ns/100ps
`include "dtc_defs.vh"

// one safety channel: two-stage synchroniser and close-debounce
module dtc_chan_filter #(
  parameter FILT_CYC = `DTC_FILT_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire chanIn,
  output reg chanClosed_q,
  output reg chanRaw_q
);

  reg sync1_q;
  reg [15:0] cnt_q;

  // synchroniser; first stage read only by the second
  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= 1'h0;
      chanRaw_q <= 1'h0;
    end else begin
      sync1_q <= chanIn;
      chanRaw_q <= sync1_q;
    end
  end

  // opening acts at once; closing must stay stable before it counts
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      chanClosed_q <= 1'h0;
    end else if (!chanRaw_q) begin
      cnt_q <= 16'h0000;
      chanClosed_q <= 1'h0;
    end else if (cnt_q < FILT_CYC) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      chanClosed_q <= 1'h1;
    end
  end

endmodule // dtc_chan_filter

// ---- tb/dtc_switch_model.sv ----
`timescale 1ns/100ps
// emergency switch pair and reset key, as plain contacts
module dtc_switch_model (
  input wire openA,
  input wire openB,
  input wire press,
  output wire safetyInputA,
  output wire safetyInputB,
  output wire resetKey
);
  // contacts close to the safety supply unless opened
  assign safetyInputA = !openA;
  assign safetyInputB = !openB;
  assign resetKey = press;
endmodule // dtc_switch_model

// ---- tb/dtc_chk_assertions.sv ----
`timescale 1ns/100ps
// pin-level checks; inputs are async, so allow the sync delay
module dtc_chk (
  input wire clock,
  input wire rst_n,
  input wire safetyInputA,
  input wire safetyInputB,
  input wire resetKey,
  input wire runCmd,
  input wire selfTestOk,
  input wire gateEnable_q,
  input wire powerSwitchOff_q,
  input wire coast_q,
  input wire safetyErr_q,
  input wire completionRelayPos_q,
  input wire completionRelayNeg_q,
  input wire selfTestFail_q
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_open_one_cut:
    assert property (!safetyInputA |-> ##[0:3] !gateEnable_q)
    else $error("gate on after channel one opened");
  chk_open_two_cut:
    assert property (!safetyInputB |-> ##[0:3] !gateEnable_q)
    else $error("gate on after channel two opened");
  chk_run_outputs:
    assert property (gateEnable_q |-> !powerSwitchOff_q && !coast_q)
    else $error("power stage off while gating on");
  chk_trip_safe:
    assert property (safetyErr_q |-> powerSwitchOff_q && coast_q
      && !gateEnable_q && !completionRelayPos_q)
    else $error("trip held without safe outputs");
  chk_relay_sides:
    assert property (completionRelayPos_q == completionRelayNeg_q
      && completionRelayPos_q == !powerSwitchOff_q)
    else $error("relay sides disagree or miss the cutoff");
  chk_gate_needs_run:
    assert property (gateEnable_q |-> $past(runCmd))
    else $error("gating on without run request");
  chk_fail_needs_bad:
    assert property ($rose(selfTestFail_q) |-> !$past(selfTestOk, 3))
    else $error("self-test fault without failed check");
  chk_no_clear_open:
    assert property ((!safetyInputA || !safetyInputB) && safetyErr_q
      |=> safetyErr_q) else $error("trip cleared with channel open");
  chk_clear_key:
    assert property ($fell(safetyErr_q) |-> $past(resetKey, 3))
    else $error("trip cleared without key");
  chk_fail_latch:
    assert property (selfTestFail_q |=> selfTestFail_q
      && !completionRelayPos_q) else $error("self-test fault lost");
endmodule // dtc_chk
bind dtc_torque_cutoff dtc_chk chk (
  .clock(clock),
  .rst_n(rst_n),
  .safetyInputA(safetyInputA),
  .safetyInputB(safetyInputB),
  .resetKey(resetKey),
  .runCmd(runCmd),
  .selfTestOk(selfTestOk),
  .gateEnable_q(gateEnable_q),
  .powerSwitchOff_q(powerSwitchOff_q),
  .coast_q(coast_q),
  .safetyErr_q(safetyErr_q),
  .completionRelayPos_q(completionRelayPos_q),
  .completionRelayNeg_q(completionRelayNeg_q),
  .selfTestFail_q(selfTestFail_q)
);

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
  reg clock = 1'h0;
  reg rst_n = 1'h0;
  reg runCmd = 1'h1;
  reg selfTestOk = 1'h1;
  reg openA = 1'h0;
  reg openB = 1'h0;
  reg press = 1'h0;
  wire safetyInputA;
  wire safetyInputB;
  wire resetKey;
  wire gate;
  wire pwrOff;
  wire coast;
  wire err;
  wire relP;
  wire relN;
  wire fail;
  integer n_mismatch = 0;
  integer total_checks = 0;

  // 50 MHz system clock
  always #10 clock = ~clock;

  dtc_switch_model sw (
    .openA(openA),
    .openB(openB),
    .press(press),
    .safetyInputA(safetyInputA),
    .safetyInputB(safetyInputB),
    .resetKey(resetKey)
  );

  dtc_torque_cutoff #(
    .TEST_CYC(16'h0040)
  ) uut (
    .clock(clock),
    .rst_n(rst_n),
    .safetyInputA(safetyInputA),
    .safetyInputB(safetyInputB),
    .resetKey(resetKey),
    .runCmd(runCmd),
    .selfTestOk(selfTestOk),
    .gateEnable_q(gate),
    .powerSwitchOff_q(pwrOff),
    .coast_q(coast),
    .safetyErr_q(err),
    .completionRelayPos_q(relP),
    .completionRelayNeg_q(relN),
    .selfTestFail_q(fail)
  );

  // all stimulus moves on falling edges
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask

  task expect_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  // reset held over four rising edges
  task do_reset;
    rst_n = 1'h0;
    cyc(4);
    rst_n = 1'h1;
  endtask

  // one key stroke, long enough for the two-stage synchroniser
  task key_stroke;
    press = 1'h1;
    cyc(10);
    press = 1'h0;
    cyc(2);
  endtask

  // filters settle only after the test window, so boot latches a
  // trip; the key clears it once both channels have settled
  task t_boot;
    do_reset;
    cyc(1200);
    key_stroke;
    expect_bit("gate", 1'h1, gate);
    expect_bit("relay", 1'h1, relP);
    runCmd = 1'h0;
    cyc(2);
    expect_bit("gate", 1'h0, gate);
    expect_bit("powerOff", 1'h0, pwrOff);
    runCmd = 1'h1;
    cyc(2);
  endtask

  // open one channel, key while open, then proper clear
  task t_trip(input logic chan);
    openA = !chan;
    openB = chan;
    cyc(5);
    expect_bit("gate", 1'h0, gate);
    expect_bit("powerOff", 1'h1, pwrOff);
    expect_bit("coast", 1'h1, coast);
    expect_bit("err", 1'h1, err);
    expect_bit("relay", 1'h0, relN);
    key_stroke;
    cyc(3);
    expect_bit("err", 1'h1, err);
    expect_bit("gate", 1'h0, gate);
    openA = 1'h0;
    openB = 1'h0;
    cyc(1100);
    key_stroke;
    expect_bit("err", 1'h0, err);
    expect_bit("gate", 1'h1, gate);
    expect_bit("coast", 1'h0, coast);
  endtask

  task t_selftest;
    selfTestOk = 1'h0;
    do_reset;
    cyc(100);
    expect_bit("fail", 1'h1, fail);
    expect_bit("relay", 1'h0, relP);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    t_boot;
    t_trip(1'h0);
    t_trip(1'h1);
    t_selftest;
    stop_test;
  end

  // run needs about 3600 cycles; cut off well beyond
  initial begin
    #400000;
    n_mismatch++;
    stop_test;
  end
endmodule // tb
